// File: bench/scsd_top_tb_top.sv
// self-checking bench of the clock source divider
`default_nettype none
`include "scsd_params.svh"
`define CHK(nm, ex, gt) \
    begin \
        cmp_count++; \
        if ((gt) !== (ex)) \
        begin \
            err_count++; \
            $display("unexpected %s exp %0h got %0h", nm, ex, gt); \
        end \
    end
module scsd_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic cry = 1'b0;
    logic fst = 1'b0;
    logic slw = 1'b0;
    logic pll = 1'b0;
    logic [1:0] pm = 2'h0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic core;
    logic [31:0] gates;
    logic cry_en;
    logic fast_en;
    logic pll_en;
    int cyc = 0;
    int err_count = 0;
    int cmp_count = 0;
    int gap = 0;
    int min_gap = 1000;
    logic gap_arm = 1'b0;
    scsd_top #(.GATE_W(32), .LOCK_COUNT(16'h0010)) dut_u (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_crystal_tick(cry),
        .i_fast_tick(fst), .i_slow_tick(slw), .i_pll_tick(pll),
        .i_power_mode(pm), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
        .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel),
        .i_wb_dat(wb_wdat), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack),
        .o_core_clock_net(core), .o_periph_clk_en(gates),
        .o_crystal_en(cry_en), .o_fast_en(fast_en), .o_pll_en(pll_en));
    initial
    begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    // oscillator ticks: crystal 3, fast 2, slow 5, pll every cycle
    // scaled crystal reference
    always @(posedge i_ref_clk)
    begin
        cyc <= cyc + 1;
        cry <= (cyc % 3 == 0);
        fst <= (cyc % 2 == 0);
        slw <= (cyc % 5 == 0);
        pll <= 1'b1;
    end
    always @(posedge i_ref_clk)
    begin
        if (core === 1'b1)
            gap <= 0;
        else
            gap <= gap + 1;
        if (!gap_arm)
            min_gap <= 1000;
        else if (core === 1'b1 && gap + 1 < min_gap)
            min_gap <= gap + 1;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic wb_io(input logic we, input logic [3:0] a, input logic [31:0] d,
                         output logic [31:0] q);
        int n;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_wdat <= d;
        n = 0;
        do
        begin
            @(posedge i_ref_clk);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 50);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (n >= 50)
        begin
            err_count++;
            complete_run();
        end
        @(posedge i_ref_clk);
    endtask : wb_io
    task automatic next_tick(output int g);
        g = 0;
        do
        begin
            @(posedge i_ref_clk);
            g++;
        end
        while (core !== 1'b1 && g < 2000);
        if (g >= 2000)
        begin
            err_count++;
            complete_run();
        end
    endtask : next_tick
    task automatic period(input string nm, input int ex);
        int g;
        next_tick(g);
        next_tick(g);
        next_tick(g);
        `CHK(nm, ex, g)
    endtask : period
    function automatic logic [31:0] ext(input logic [1:0] s, input logic [5:0] d,
                                        input logic skip, input logic off);
        logic [31:0] v;
        v = 32'h0;
        v[`SCSD_F_USE_EXT] = 1'b1;
        v[`SCSD_F_DIV_LO +: 6] = d;
        v[`SCSD_F_SKIP] = skip;
        v[`SCSD_F_PLL_OFF] = off;
        v[`SCSD_F_SRC_LO +: 2] = s;
        return v;
    endfunction : ext
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] q;
        period("reset period", 32);
        wb_io(1'b0, `SCSD_ADDR_STATUS, 32'h0, q);
        `CHK("reset source", 2'h1, q[1:0])
        `CHK("reset pll enable", 1'b0, pll_en)
        `CHK("reset crystal enable", 1'b0, cry_en)
        `CHK("reset fast enable", 1'b1, fast_en)
    endtask : t_reset
    task automatic t_sources;
        logic [31:0] q;
        int per[4] = '{3, 2, 8, 5};
        logic [5:0] dv[4] = '{6'h03, 6'h09, 6'h3f, 6'h01};
        wb_io(1'b1, `SCSD_ADDR_CFG, 32'h0780_2810, q);
        `CHK("crystal enable", 1'b1, cry_en)
        for (int s = 0; s < 4; s++)
        begin
            wb_io(1'b1, `SCSD_ADDR_CFG_EXT, ext(s[1:0], dv[s], 1'b1, 1'b1), q);
            period("source period", per[s] * (dv[s] + 1));
            wb_io(1'b0, `SCSD_ADDR_STATUS, 32'h0, q);
            `CHK("active source", s[1:0], q[1:0])
        end
        q = ext(2'h3, 6'h01, 1'b1, 1'b1);
        q[`SCSD_F_USE_EXT] = 1'b0;
        wb_io(1'b1, `SCSD_ADDR_CFG_EXT, q, q);
        period("primary period", 32);
    endtask : t_sources
    task automatic t_pll;
        logic [31:0] q;
        int n;
        wb_io(1'b1, `SCSD_ADDR_CFG_EXT, ext(2'h0, 6'h09, 1'b1, 1'b1), q);
        wb_io(1'b1, `SCSD_ADDR_CFG_EXT, ext(2'h0, 6'h09, 1'b0, 1'b0), q);
        wb_io(1'b0, `SCSD_ADDR_STATUS, 32'h0, q);
        `CHK("pll early", 2'h0, q[3:2])
        n = 0;
        while (q[3] !== 1'b1 && n < 200)
        begin
            wb_io(1'b0, `SCSD_ADDR_STATUS, 32'h0, q);
            n++;
        end
        `CHK("lock wait", 1'b1, (n >= 15 && n < 200))
        `CHK("pll enable", 1'b1, pll_en)
        period("pll div10", 20);
        wb_io(1'b1, `SCSD_ADDR_CFG_EXT, ext(2'h0, 6'h07, 1'b0, 1'b0), q);
        period("pll div8", 16);
    endtask : t_pll
    task automatic t_sleep;
        logic [31:0] q;
        wb_io(1'b1, `SCSD_ADDR_CFG_EXT, ext(2'h1, 6'h03, 1'b1, 1'b1), q);
        wb_io(1'b1, `SCSD_ADDR_CFG, 32'h3200_2810, q);
        pm <= 2'h1;
        period("sleep period", 32);
        pm <= 2'h2;
        period("deep period", 20);
        wb_io(1'b0, `SCSD_ADDR_STATUS, 32'h0, q);
        `CHK("deep source", 2'h3, q[1:0])
        pm <= 2'h0;
        period("run period", 8);
    endtask : t_sleep
    task automatic t_gate;
        logic [31:0] q;
        wb_io(1'b1, `SCSD_ADDR_GATE, 32'h0000_0005, q);
        repeat (40)
        begin
            @(posedge i_ref_clk);
            `CHK("gates", 32'h5 & {32{core}}, gates)
        end
    endtask : t_gate
    task automatic t_unmapped;
        logic [31:0] a;
        logic [31:0] b;
        wb_io(1'b0, `SCSD_ADDR_CFG, 32'h0, a);
        wb_io(1'b1, 4'h2, 32'hffff_ffff, b);
        wb_io(1'b0, 4'h2, 32'h0, b);
        `CHK("unmapped read", 32'h0, b)
        wb_io(1'b0, `SCSD_ADDR_CFG, 32'h0, b);
        `CHK("cfg kept", a, b)
    endtask : t_unmapped
    task automatic t_switch;
        logic [31:0] q;
        int g;
        wb_io(1'b1, `SCSD_ADDR_CFG_EXT, ext(2'h1, 6'h0f, 1'b1, 1'b1), q);
        period("slow divisor", 32);
        repeat (5) @(posedge i_ref_clk);
        gap_arm <= 1'b1;
        wb_io(1'b1, `SCSD_ADDR_CFG_EXT, ext(2'h1, 6'h01, 1'b1, 1'b1), q);
        repeat (4)
        begin
            next_tick(g);
            #1;
            `CHK("no short pulse", 1'b1, min_gap >= 4)
        end
        `CHK("new divisor", 4, g)
    endtask : t_switch
    initial
    begin
        repeat (8) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        @(posedge i_ref_clk);
        t_reset();
        t_sources();
        t_pll();
        t_sleep();
        t_gate();
        t_unmapped();
        t_switch();
        complete_run();
    end
endmodule : scsd_top_tb_top
`default_nettype wire

// File: inc/scsd_params.svh
// constants for the system clock source divider
`ifndef SCSD_PARAMS_SVH
`define SCSD_PARAMS_SVH
`define SCSD_ADDR_CFG 4'h0
`define SCSD_ADDR_CFG_EXT 4'h4
`define SCSD_ADDR_STATUS 4'h8
`define SCSD_ADDR_GATE 4'hc
`define SCSD_CFG_RESET 32'h0780_2ed1
`define SCSD_CFG_EXT_RESET 32'h0780_0010
`define SCSD_GATE_RESET 32'h0000_0000
`define SCSD_LOCK_COUNT 16'h1200
// field positions
`define SCSD_F_SKIP 11
`define SCSD_F_PLL_OFF 13
`define SCSD_F_CRYSTAL_OFF 0
`define SCSD_F_FAST_OFF 1
`define SCSD_F_SRC_LO 4
`define SCSD_F_DIV_LO 23
`define SCSD_F_USE_EXT 31
`define SCSD_F_SLEEP_SRC_LO 24
`define SCSD_F_DEEP_SRC_LO 28
`endif

// File: inc/scsd_pkg.sv
// types of the system clock source divider
`default_nettype none
package scsd_pkg;
    typedef enum logic [1:0]
    {
        SCSD_SRC_CRYSTAL = 2'h0,
        SCSD_SRC_FAST = 2'h1,
        SCSD_SRC_FAST_DIV4 = 2'h2,
        SCSD_SRC_SLOW = 2'h3
    } scsd_src_t;
    typedef enum logic [1:0]
    {
        SCSD_MODE_RUN = 2'h0,
        SCSD_MODE_SLEEP = 2'h1,
        SCSD_MODE_DEEP = 2'h2
    } scsd_mode_t;
endpackage : scsd_pkg
`default_nettype wire

// File: src/scsd_divider.sv
// integer divider giving one-cycle core clock enables
`default_nettype none
module scsd_divider
#(
    parameter int unsigned DIV_W = 7
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_src_tick,
    input wire logic [DIV_W-1:0] i_factor,
    output logic o_tick
);
    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    logic tick_nxt;
    logic tick_r;
    initial
    begin
        if (DIV_W < 2)
            $error("divider width too small");
    end
    // factor compared on every source tick, so a new factor takes effect at once
    always_comb
    begin
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (i_src_tick)
        begin
            if (cnt_r + 1'b1 >= i_factor)
            begin
                cnt_nxt = '0;
                tick_nxt = 1'b1;
            end
            else
                cnt_nxt = cnt_r + 1'b1;
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end
    assign o_tick = tick_r;
endmodule : scsd_divider
`default_nettype wire

// File: src/scsd_lock_timer.sv
// pll lock wait down-counter on the crystal tick
`default_nettype none
`include "scsd_params.svh"
module scsd_lock_timer
#(
    parameter int unsigned COUNT_W = 16,
    parameter logic [15:0] LOCK_COUNT = `SCSD_LOCK_COUNT
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_crystal_tick,
    input wire logic i_restart,
    output logic o_locked
);
    logic [COUNT_W-1:0] cnt_r;
    logic [COUNT_W-1:0] cnt_nxt;
    initial
    begin
        if (COUNT_W < 13 || COUNT_W > 16)
            $error("lock counter width out of range");
    end
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (i_restart)
            cnt_nxt = LOCK_COUNT[COUNT_W-1:0];
        else if (i_crystal_tick && cnt_r != '0)
            cnt_nxt = cnt_r - 1'b1;
    end
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt_r <= LOCK_COUNT[COUNT_W-1:0];
        else
            cnt_r <= cnt_nxt;
    end
    assign o_locked = (cnt_r == '0);
    chk_lock_reload : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_restart |=> !o_locked)
        else $error("lock not cleared on restart");
endmodule : scsd_lock_timer
`default_nettype wire

// File: src/scsd_top.sv
// system clock source selection, divisor and wishbone registers
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`default_nettype none
`include "scsd_params.svh"
module scsd_top
#(
    parameter int unsigned GATE_W = 32,
    parameter logic [15:0] LOCK_COUNT = `SCSD_LOCK_COUNT
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_crystal_tick,
    input wire logic i_fast_tick,
    input wire logic i_slow_tick,
    input wire logic i_pll_tick,
    input wire logic [1:0] i_power_mode,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_core_clock_net,
    output logic [GATE_W-1:0] o_periph_clk_en,
    output logic o_crystal_en,
    output logic o_fast_en,
    output logic o_pll_en
);
    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] run_clock_config_r;
    logic [31:0] run_clock_config_nxt;
    logic [31:0] run_clock_config_ext_r;
    logic [31:0] run_clock_config_ext_nxt;
    logic [GATE_W-1:0] gate_r;
    logic [GATE_W-1:0] gate_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;
    logic wr_cfg;
    logic wr_ext;
    logic use_ext_config;
    logic skip;
    logic pll_off;
    logic [1:0] source_pick;
    logic [5:0] core_clock_net_divisor;
    logic [1:0] mode_src;
    logic pll_cfg_change;
    logic locked;
    logic src_tick;
    logic half_r;
    logic half_nxt;
    logic pll_half_tick;
    logic use_pll;
    logic [6:0] factor;
    logic core_tick;
    logic core_r;
    logic [GATE_W-1:0] gate_out_r;
    logic [2:0] en_r;
    logic [1:0] fdiv4_r;
    logic [1:0] fdiv4_nxt;
    logic core_nxt;
    logic [GATE_W-1:0] gate_out_nxt;
    logic [2:0] en_nxt;
    initial
    begin
        if (GATE_W < 1 || GATE_W > 32)
            $error("gate width out of range");
    end

    function automatic logic [31:0] merge_sel(input logic [31:0] old,
        input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                res[i*8 +: 8] = dat[i*8 +: 8];
        end
        return res;
    endfunction : merge_sel

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave, one wait state, unmapped reads zero
    assign wr_cfg = i_wb_cyc && i_wb_stb && i_wb_we && !ack_r && i_wb_adr == `SCSD_ADDR_CFG;
    assign wr_ext = i_wb_cyc && i_wb_stb && i_wb_we && !ack_r
        && i_wb_adr == `SCSD_ADDR_CFG_EXT;
    always_comb
    begin
        ack_nxt = i_wb_cyc && i_wb_stb && !ack_r;
        run_clock_config_nxt = run_clock_config_r;
        run_clock_config_ext_nxt = run_clock_config_ext_r;
        gate_nxt = gate_r;
        rdat_nxt = 32'h0000_0000;
        if (wr_cfg)
            run_clock_config_nxt = merge_sel(run_clock_config_r, i_wb_dat, i_wb_sel);
        if (wr_ext)
            run_clock_config_ext_nxt = merge_sel(run_clock_config_ext_r, i_wb_dat, i_wb_sel);
        if (i_wb_cyc && i_wb_stb && i_wb_we && !ack_r && i_wb_adr == `SCSD_ADDR_GATE)
            gate_nxt = GATE_W'(merge_sel(32'(gate_r), i_wb_dat, i_wb_sel));
        if (i_wb_cyc && i_wb_stb && !i_wb_we && !ack_r)
        begin
            unique case (i_wb_adr)
                `SCSD_ADDR_CFG: rdat_nxt = run_clock_config_r;
                `SCSD_ADDR_CFG_EXT: rdat_nxt = run_clock_config_ext_r;
                `SCSD_ADDR_STATUS: rdat_nxt = {28'h000_0000, use_pll, locked, source_pick};
                `SCSD_ADDR_GATE: rdat_nxt = 32'(gate_r);
                default: rdat_nxt = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            run_clock_config_r <= `SCSD_CFG_RESET;
            run_clock_config_ext_r <= `SCSD_CFG_EXT_RESET;
            gate_r <= GATE_W'(`SCSD_GATE_RESET);
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end
        else
        begin
            run_clock_config_r <= run_clock_config_nxt;
            run_clock_config_ext_r <= run_clock_config_ext_nxt;
            gate_r <= gate_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end
    assign o_wb_ack = ack_r;
    assign o_wb_dat = rdat_r;

    ////////////////////////////////////////////////////////////////////////////
    // field selection
    assign use_ext_config = run_clock_config_ext_r[`SCSD_F_USE_EXT];
    always_comb
    begin
        if (use_ext_config)
        begin
            skip = run_clock_config_ext_r[`SCSD_F_SKIP];
            pll_off = run_clock_config_ext_r[`SCSD_F_PLL_OFF];
            mode_src = run_clock_config_ext_r[`SCSD_F_SRC_LO +: 2];
            core_clock_net_divisor = run_clock_config_ext_r[`SCSD_F_DIV_LO +: 6];
        end
        else
        begin
            skip = run_clock_config_r[`SCSD_F_SKIP];
            pll_off = run_clock_config_r[`SCSD_F_PLL_OFF];
            mode_src = run_clock_config_r[`SCSD_F_SRC_LO +: 2];
            core_clock_net_divisor = {2'h0, run_clock_config_r[`SCSD_F_DIV_LO +: 4]};
        end
        // deep sleep may use 30 kHz
        unique case (i_power_mode)
            scsd_pkg::SCSD_MODE_SLEEP: source_pick = run_clock_config_r[`SCSD_F_SLEEP_SRC_LO +: 2];
            scsd_pkg::SCSD_MODE_DEEP: source_pick = run_clock_config_r[`SCSD_F_DEEP_SRC_LO +: 2];
            default: source_pick = mode_src;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // pll lock wait
    assign pll_cfg_change = (wr_cfg || wr_ext) && (pll_off != (use_ext_config ?
        run_clock_config_ext_nxt[`SCSD_F_PLL_OFF] : run_clock_config_nxt[`SCSD_F_PLL_OFF]));
    scsd_lock_timer #(.COUNT_W(16), .LOCK_COUNT(LOCK_COUNT)) u_lock
    (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_crystal_tick(i_crystal_tick),
        .i_restart(pll_cfg_change),
        .o_locked(locked)
    );
    assign use_pll = !skip && !pll_off && locked
        && source_pick == scsd_pkg::SCSD_SRC_CRYSTAL && i_power_mode == scsd_pkg::SCSD_MODE_RUN;

    ////////////////////////////////////////////////////////////////////////////
    // source pick and pll halving
    // halve pll first
    always_comb
    begin
        half_nxt = half_r ^ i_pll_tick;
    end
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            half_r <= 1'b0;
        else
            half_r <= half_nxt;
    end
    assign pll_half_tick = i_pll_tick && half_r;
    always_comb
    begin
        if (use_pll)
            src_tick = pll_half_tick;
        else
        begin
            unique case (scsd_pkg::scsd_src_t'(source_pick))
                scsd_pkg::SCSD_SRC_CRYSTAL: src_tick = i_crystal_tick;
                scsd_pkg::SCSD_SRC_FAST: src_tick = i_fast_tick;
                scsd_pkg::SCSD_SRC_FAST_DIV4: src_tick = i_fast_tick && fdiv4_r == 2'h3;
                scsd_pkg::SCSD_SRC_SLOW: src_tick = i_slow_tick;
            endcase
        end
    end
    // fast oscillator quarter rate
    always_comb
    begin
        fdiv4_nxt = fdiv4_r + 2'(i_fast_tick);
    end
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            fdiv4_r <= 2'h0;
        else
            fdiv4_r <= fdiv4_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // divisor
    // divisor on chosen source
    assign factor = 7'(core_clock_net_divisor) + 7'h01;
    scsd_divider #(.DIV_W(7)) u_div
    (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_src_tick(src_tick),
        .i_factor(factor),
        .o_tick(core_tick)
    );
    always_comb
    begin
        core_nxt = core_tick;
        gate_out_nxt = gate_r & {GATE_W{core_tick}};
        en_nxt = {~pll_off, ~run_clock_config_r[`SCSD_F_FAST_OFF],
            ~run_clock_config_r[`SCSD_F_CRYSTAL_OFF]};
    end
    // output flip-flops
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            core_r <= 1'b0;
            gate_out_r <= '0;
            en_r <= 3'h0;
        end
        else
        begin
            core_r <= core_nxt;
            gate_out_r <= gate_out_nxt;
            en_r <= en_nxt;
        end
    end
    assign o_core_clock_net = core_r;
    assign o_periph_clk_en = gate_out_r;
    assign o_crystal_en = en_r[0];
    assign o_fast_en = en_r[1];
    assign o_pll_en = en_r[2];

    ////////////////////////////////////////////////////////////////////////////
    // bus and clock selection checks
    chk_pll_needs_lock : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        use_pll |-> locked && !skip)
        else $error("pll used before lock");
    chk_wb_ack_once : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        ack_r |=> !ack_r)
        else $error("ack held two cycles");
    chk_core_gate : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        !core_r |-> o_periph_clk_en == '0)
        else $error("peripheral enable without core tick");
    chk_reset_src : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(i_rst_n) |-> !use_pll)
        else $error("pll after reset");
    chk_lock_restart : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        pll_cfg_change |=> !use_pll)
        else $error("pll used right after a pll change");
    chk_skip_no_pll : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        skip |-> !use_pll)
        else $error("pll used with skip set");
    chk_wb_ack_answer : assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_wb_cyc && i_wb_stb && !ack_r |=> ack_r)
        else $error("request not acknowledged");

    // scenario covers
    cov_pll_used : cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) use_pll);
    cov_ext_used : cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) use_ext_config);
    cov_deep : cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_power_mode == scsd_pkg::SCSD_MODE_DEEP && core_r);
    cov_sleep : cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_power_mode == scsd_pkg::SCSD_MODE_SLEEP && core_r);
    cov_lock_restart : cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        pll_cfg_change);
endmodule : scsd_top
`default_nettype wire
